// ==== mcuic_pkg.sv ====
package mcuic_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_EXTRA_PRIO = 8'h96;
   localparam logic [7:0] ADDR_ENABLE_MAIN = 8'ha8;
   localparam logic [7:0] ADDR_KB_SELECT = 8'ha9;
   localparam logic [7:0] ADDR_PRIO_MAIN = 8'hb8;
   localparam logic [7:0] ADDR_FLAG_LO = 8'hc0;
   localparam logic [7:0] ADDR_FLAG_HI = 8'hc1;
   localparam logic [7:0] ADDR_PIN_EN = 8'hc2;
   localparam logic [7:0] ADDR_PIN_EDGE = 8'hc3;
   localparam logic [7:0] ADDR_PIN_POL = 8'hc4;
   localparam logic [7:0] ADDR_TIMER_EN = 8'hc5;
   localparam logic [7:0] ADDR_STATUS = 8'hc6;
   localparam logic [7:0] ADDR_ENABLE_EXT = 8'he8;
   localparam logic [7:0] ADDR_PRIO_EXT = 8'hf8;

   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [15:0] RST_FLAGS = 16'h0000;
   localparam logic [15:0] RST_PC = 16'h0000;

   localparam int NUM_PINS = 5;
   localparam int NUM_KEYS = 8;
   localparam int NUM_FLAGS = 16;
   localparam int NUM_VEC = 15;
   localparam int STACK_DEPTH = 2;

   // Global enable position in the main enable register
   localparam int GLOBAL_EN_BIT = 7;

   // Flag positions: low byte 0..7, high byte 8..15
   localparam int F_PIN0 = 0;
   localparam int F_TMR0 = 1;
   localparam int F_PIN1 = 2;
   localparam int F_TMR1 = 3;
   localparam int F_UTX = 4;
   localparam int F_URX = 5;
   localparam int F_TMA = 6;
   localparam int F_TMB = 7;
   localparam int F_TMR2 = 8;
   localparam int F_KBD = 9;
   localparam int F_PIN2 = 10;
   localparam int F_TWI = 11;
   localparam int F_LVD = 12;
   localparam int F_PIN3 = 13;
   localparam int F_PIN4 = 14;
   localparam int F_WDG = 15;

   // Flags cleared by hardware on vector entry: pins 0/1, timers 0/1
   localparam logic [15:0] HW_CLR_MASK = 16'h000f;

   // Per vector, bit index into {ext, timer, main} enables and into
   // {ext, extra, main} priorities; both maps share one layout.
   localparam logic [4:0] SRC_BIT [NUM_VEC] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h09, 5'h0a, 5'h05,
      5'h17, 5'h10, 5'h08, 5'h13, 5'h11, 5'h12, 5'h15
   };

   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [3:0] NO_WINNER = 4'hf;

   typedef enum logic [1:0] {
      LVL_NONE = 2'b00,
      LVL_LOW = 2'b01,
      LVL_HIGH = 2'b10,
      LVL_BOTH = 2'b11
   } mcuic_level_t;

endpackage

// ==== mcuic_pin_trig.sv ====
`timescale 1ns/1ns
module mcuic_pin_trig (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic pin_async,
   input wire logic trig_en,
   input wire logic edge_mode,
   input wire logic active_high,
   input wire logic any_edge,
   output logic trig_evt
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic changed;
   logic at_level;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q <= 1'h0;
         sync_q <= 1'h0;
         prev_q <= 1'h0;
      end else begin
         meta_q <= pin_async;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign changed = sync_q != prev_q;
   assign at_level = sync_q == active_high;
   // Level mode keeps firing while the pin sits at its active level
   assign trig_evt = trig_en & (any_edge ? changed :
                                edge_mode ? (changed & at_level) : at_level);
endmodule

// ==== mcuic_top.sv ====
`timescale 1ns/1ns
module mcuic_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [4:0] ext_pin,
   input wire logic [7:0] kb_pin,
   input wire logic timer_zero_evt,
   input wire logic timer_one_evt,
   input wire logic uart_tx_evt,
   input wire logic uart_rx_evt,
   input wire logic timer_a_evt,
   input wire logic timer_b_evt,
   input wire logic timer_two_evt,
   input wire logic two_wire_evt,
   input wire logic low_voltage_evt,
   input wire logic watchdog_evt,
   input wire logic cpu_boundary,
   input wire logic [15:0] cpu_pc,
   input wire logic cpu_reti,
   output logic irq_pending,
   output logic irq_take,
   output logic [15:0] irq_vector,
   output logic irq_level,
   output logic ret_valid,
   output logic [15:0] ret_pc
);
   // Software registers
   logic [7:0] enable_main_q;
   logic [7:0] enable_ext_q;
   logic [7:0] timer_en_q;
   logic [7:0] prio_main_q;
   logic [7:0] prio_ext_q;
   logic [7:0] extra_prio_q;
   logic [7:0] kb_select_q;
   logic [7:0] pin_en_q;
   logic [7:0] pin_edge_q;
   logic [7:0] pin_pol_q;
   logic [15:0] flag_q;
   logic [15:0] flag_d;

   // Request and service state
   logic [14:0] req_q;
   logic [14:0] vec_req;
   logic [14:0] vec_en;
   logic [14:0] vec_prio;
   logic [14:0] src_flag;
   logic [23:0] en_all;
   logic [23:0] prio_all;
   mcuic_pkg::mcuic_level_t lvl_q;
   mcuic_pkg::mcuic_level_t lvl_d;
   logic [15:0] stack_q [mcuic_pkg::STACK_DEPTH];
   logic [1:0] sp_q;

   // Output flops
   logic [7:0] reg_rdata_q;
   logic irq_pending_q;
   logic irq_take_q;
   logic [15:0] irq_vector_q;
   logic irq_level_q;
   logic ret_valid_q;
   logic [15:0] ret_pc_q;

   // Event wires
   logic [4:0] pin_evt;
   logic [7:0] key_evt;
   logic [15:0] evt_vec;
   logic [15:0] sw_clr;
   logic [15:0] hw_clr;

   // Write decode
   logic wr_enable_main;
   logic wr_enable_ext;
   logic wr_timer_en;
   logic wr_prio_main;
   logic wr_prio_ext;
   logic wr_extra_prio;
   logic wr_kb_select;
   logic wr_pin_en;
   logic wr_pin_edge;
   logic wr_pin_pol;
   logic wr_flag_lo;
   logic wr_flag_hi;
   logic [7:0] rd_mux;

   // Arbitration
   logic global_on;
   logic [14:0] hi_req;
   logic [14:0] lo_req;
   logic [3:0] hi_idx;
   logic [3:0] lo_idx;
   logic [3:0] win_idx;
   logic in_high;
   logic take_hi;
   logic take_lo;
   logic take_now;
   logic pop_now;

   function automatic logic [3:0] first_set(input logic [14:0] v);
      logic [3:0] idx;
      idx = mcuic_pkg::NO_WINNER;
      for (int i = 14; i >= 0; i--) begin
         if (v[i]) begin
            idx = i[3:0];
         end
      end
      return idx;
   endfunction

   // External pins, each with private trigger setup
   for (genvar p = 0; p < mcuic_pkg::NUM_PINS; p++) begin : g_pin
      mcuic_pin_trig u_trig (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .pin_async(ext_pin[p]),
         .trig_en(pin_en_q[p]),
         .edge_mode(pin_edge_q[p]),
         .active_high(pin_pol_q[p]),
         .any_edge(1'h0),
         .trig_evt(pin_evt[p])
      );
   end

   // Keyboard inputs: any transition on a selected line
   for (genvar k = 0; k < mcuic_pkg::NUM_KEYS; k++) begin : g_key
      mcuic_pin_trig u_trig (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .pin_async(kb_pin[k]),
         .trig_en(kb_select_q[k]),
         .edge_mode(1'h1),
         .active_high(1'h1),
         .any_edge(1'h1),
         .trig_evt(key_evt[k])
      );
   end

   // Source events into flag positions
   assign evt_vec[mcuic_pkg::F_PIN0] = pin_evt[0];
   assign evt_vec[mcuic_pkg::F_TMR0] = timer_zero_evt;
   assign evt_vec[mcuic_pkg::F_PIN1] = pin_evt[1];
   assign evt_vec[mcuic_pkg::F_TMR1] = timer_one_evt;
   assign evt_vec[mcuic_pkg::F_UTX] = uart_tx_evt;
   assign evt_vec[mcuic_pkg::F_URX] = uart_rx_evt;
   assign evt_vec[mcuic_pkg::F_TMA] = timer_a_evt;
   assign evt_vec[mcuic_pkg::F_TMB] = timer_b_evt;
   assign evt_vec[mcuic_pkg::F_TMR2] = timer_two_evt;
   assign evt_vec[mcuic_pkg::F_KBD] = |key_evt;
   assign evt_vec[mcuic_pkg::F_PIN2] = pin_evt[2];
   assign evt_vec[mcuic_pkg::F_TWI] = two_wire_evt;
   assign evt_vec[mcuic_pkg::F_LVD] = low_voltage_evt;
   assign evt_vec[mcuic_pkg::F_PIN3] = pin_evt[3];
   assign evt_vec[mcuic_pkg::F_PIN4] = pin_evt[4];
   assign evt_vec[mcuic_pkg::F_WDG] = watchdog_evt;

   // Register decode
   assign wr_enable_main = reg_wr & (reg_addr == mcuic_pkg::ADDR_ENABLE_MAIN);
   assign wr_enable_ext = reg_wr & (reg_addr == mcuic_pkg::ADDR_ENABLE_EXT);
   assign wr_timer_en = reg_wr & (reg_addr == mcuic_pkg::ADDR_TIMER_EN);
   assign wr_prio_main = reg_wr & (reg_addr == mcuic_pkg::ADDR_PRIO_MAIN);
   assign wr_prio_ext = reg_wr & (reg_addr == mcuic_pkg::ADDR_PRIO_EXT);
   assign wr_extra_prio = reg_wr & (reg_addr == mcuic_pkg::ADDR_EXTRA_PRIO);
   assign wr_kb_select = reg_wr & (reg_addr == mcuic_pkg::ADDR_KB_SELECT);
   assign wr_pin_en = reg_wr & (reg_addr == mcuic_pkg::ADDR_PIN_EN);
   assign wr_pin_edge = reg_wr & (reg_addr == mcuic_pkg::ADDR_PIN_EDGE);
   assign wr_pin_pol = reg_wr & (reg_addr == mcuic_pkg::ADDR_PIN_POL);
   assign wr_flag_lo = reg_wr & (reg_addr == mcuic_pkg::ADDR_FLAG_LO);
   assign wr_flag_hi = reg_wr & (reg_addr == mcuic_pkg::ADDR_FLAG_HI);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enable_main_q <= mcuic_pkg::RST_VAL;
         enable_ext_q <= mcuic_pkg::RST_VAL;
         timer_en_q <= mcuic_pkg::RST_VAL;
         prio_main_q <= mcuic_pkg::RST_VAL;
         prio_ext_q <= mcuic_pkg::RST_VAL;
         extra_prio_q <= mcuic_pkg::RST_VAL;
      end else begin
         if (wr_enable_main) enable_main_q <= reg_wdata;
         if (wr_enable_ext) enable_ext_q <= reg_wdata;
         if (wr_timer_en) timer_en_q <= reg_wdata;
         if (wr_prio_main) prio_main_q <= reg_wdata;
         if (wr_prio_ext) prio_ext_q <= reg_wdata;
         if (wr_extra_prio) extra_prio_q <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         kb_select_q <= mcuic_pkg::RST_VAL;
         pin_en_q <= mcuic_pkg::RST_VAL;
         pin_edge_q <= mcuic_pkg::RST_VAL;
         pin_pol_q <= mcuic_pkg::RST_VAL;
      end else begin
         if (wr_kb_select) kb_select_q <= reg_wdata;
         if (wr_pin_en) pin_en_q <= reg_wdata;
         if (wr_pin_edge) pin_edge_q <= reg_wdata;
         if (wr_pin_pol) pin_pol_q <= reg_wdata;
      end
   end

   // Flags: writing 0 clears, writing 1 leaves alone; a new event wins
   assign sw_clr = {wr_flag_hi ? ~reg_wdata : 8'h00,
                    wr_flag_lo ? ~reg_wdata : 8'h00};
   assign hw_clr = take_now ? (mcuic_pkg::HW_CLR_MASK & (16'h0001 << win_idx)) :
                   16'h0000;
   assign flag_d = (flag_q & ~sw_clr & ~hw_clr) | evt_vec;

   always_ff @(posedge core_clk) begin
      if (sys_rst) flag_q <= mcuic_pkg::RST_FLAGS;
      else flag_q <= flag_d;
   end

   // Per-vector enable, priority and flag
   assign en_all = {enable_ext_q, timer_en_q, enable_main_q};
   assign prio_all = {prio_ext_q, extra_prio_q, prio_main_q};
   assign global_on = enable_main_q[mcuic_pkg::GLOBAL_EN_BIT];

   for (genvar v = 0; v < mcuic_pkg::NUM_VEC; v++) begin : g_vec
      assign vec_en[v] = en_all[mcuic_pkg::SRC_BIT[v]];
      assign vec_prio[v] = prio_all[mcuic_pkg::SRC_BIT[v]];
      if (v < 4) begin : g_direct
         assign src_flag[v] = flag_q[v];
      end else if (v == 4) begin : g_uart
         // Transmit and receive share one vector
         assign src_flag[v] = flag_q[mcuic_pkg::F_UTX] | flag_q[mcuic_pkg::F_URX];
      end else begin : g_shift
         assign src_flag[v] = flag_q[v + 1];
      end
   end

   assign vec_req = src_flag & vec_en & {mcuic_pkg::NUM_VEC{global_on}};

   // Registered once per clock so the boundary sees last cycle's requests
   always_ff @(posedge core_clk) begin
      if (sys_rst) req_q <= 15'h0000;
      else req_q <= vec_req;
   end

   assign hi_req = req_q & vec_prio;
   assign lo_req = req_q & ~vec_prio;
   assign hi_idx = first_set(hi_req);
   assign lo_idx = first_set(lo_req);
   assign in_high = (lvl_q == mcuic_pkg::LVL_HIGH) || (lvl_q == mcuic_pkg::LVL_BOTH);

   // A return in the same cycle as a boundary is handled first
   assign take_hi = cpu_boundary & ~cpu_reti & (|hi_req) & ~in_high;
   assign take_lo = cpu_boundary & ~cpu_reti & (|lo_req) & ~take_hi &
                    (lvl_q == mcuic_pkg::LVL_NONE);
   assign take_now = take_hi | take_lo;
   assign win_idx = take_hi ? hi_idx : lo_idx;
   assign pop_now = cpu_reti & (sp_q != 2'h0);

   always_comb begin
      lvl_d = lvl_q;
      unique case (lvl_q)
         mcuic_pkg::LVL_NONE: begin
            if (take_hi) lvl_d = mcuic_pkg::LVL_HIGH;
            else if (take_lo) lvl_d = mcuic_pkg::LVL_LOW;
         end
         mcuic_pkg::LVL_LOW: begin
            if (cpu_reti) lvl_d = mcuic_pkg::LVL_NONE;
            else if (take_hi) lvl_d = mcuic_pkg::LVL_BOTH;
         end
         mcuic_pkg::LVL_HIGH: begin
            if (cpu_reti) lvl_d = mcuic_pkg::LVL_NONE;
         end
         mcuic_pkg::LVL_BOTH: begin
            if (cpu_reti) lvl_d = mcuic_pkg::LVL_LOW;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) lvl_q <= mcuic_pkg::LVL_NONE;
      else lvl_q <= lvl_d;
   end

   // Return stack; two levels of nesting need two entries
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sp_q <= 2'h0;
         stack_q[0] <= mcuic_pkg::RST_PC;
         stack_q[1] <= mcuic_pkg::RST_PC;
      end else if (take_now) begin
         stack_q[sp_q[0]] <= cpu_pc;
         sp_q <= sp_q + 2'h1;
      end else if (pop_now) begin
         sp_q <= sp_q - 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_take_q <= 1'h0;
         irq_vector_q <= mcuic_pkg::RST_PC;
         irq_level_q <= 1'h0;
         ret_valid_q <= 1'h0;
         ret_pc_q <= mcuic_pkg::RST_PC;
         irq_pending_q <= 1'h0;
      end else begin
         irq_take_q <= take_now;
         if (take_now) begin
            irq_vector_q <= mcuic_pkg::VEC_BASE + {9'h000, win_idx, 3'h0};
            irq_level_q <= take_hi;
         end
         ret_valid_q <= pop_now;
         if (pop_now) ret_pc_q <= stack_q[sp_q[1]];
         irq_pending_q <= |vec_req;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   assign rd_mux =
      (reg_addr == mcuic_pkg::ADDR_ENABLE_MAIN) ? enable_main_q :
      (reg_addr == mcuic_pkg::ADDR_ENABLE_EXT) ? enable_ext_q :
      (reg_addr == mcuic_pkg::ADDR_TIMER_EN) ? timer_en_q :
      (reg_addr == mcuic_pkg::ADDR_PRIO_MAIN) ? prio_main_q :
      (reg_addr == mcuic_pkg::ADDR_PRIO_EXT) ? prio_ext_q :
      (reg_addr == mcuic_pkg::ADDR_EXTRA_PRIO) ? extra_prio_q :
      (reg_addr == mcuic_pkg::ADDR_KB_SELECT) ? kb_select_q :
      (reg_addr == mcuic_pkg::ADDR_PIN_EN) ? pin_en_q :
      (reg_addr == mcuic_pkg::ADDR_PIN_EDGE) ? pin_edge_q :
      (reg_addr == mcuic_pkg::ADDR_PIN_POL) ? pin_pol_q :
      (reg_addr == mcuic_pkg::ADDR_FLAG_LO) ? flag_q[7:0] :
      (reg_addr == mcuic_pkg::ADDR_FLAG_HI) ? flag_q[15:8] :
      (reg_addr == mcuic_pkg::ADDR_STATUS) ? {4'h0, sp_q, lvl_q} :
      8'h00;

   always_ff @(posedge core_clk) begin
      if (sys_rst) reg_rdata_q <= mcuic_pkg::RST_VAL;
      else if (reg_rd) reg_rdata_q <= rd_mux;
      else reg_rdata_q <= 8'h00;
   end

   assign reg_rdata = reg_rdata_q;
   assign irq_pending = irq_pending_q;
   assign irq_take = irq_take_q;
   assign irq_vector = irq_vector_q;
   assign irq_level = irq_level_q;
   assign ret_valid = ret_valid_q;
   assign ret_pc = ret_pc_q;
endmodule

// ==== mcuic_properties.sv ====
`timescale 1ns/1ns
module mcuic_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic cpu_boundary,
   input wire logic [15:0] cpu_pc,
   input wire logic cpu_reti,
   input wire logic irq_pending,
   input wire logic irq_take,
   input wire logic [15:0] irq_vector,
   input wire logic irq_level,
   input wire logic ret_valid,
   input wire logic [15:0] ret_pc
);
   // Shadows of the global enable and the return stack, rebuilt from the ports
   logic ge_q;
   logic [1:0] dep_q;
   logic [15:0] pc_q;
   logic [15:0] stk_q [2];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge core_clk) begin
      pc_q <= cpu_pc;
      if (sys_rst) begin
         ge_q <= 1'b0;
         dep_q <= 2'h0;
      end else begin
         if (reg_wr && reg_addr == mcuic_pkg::ADDR_ENABLE_MAIN) begin
            ge_q <= reg_wdata[mcuic_pkg::GLOBAL_EN_BIT];
         end
         if (irq_take) begin
            stk_q[dep_q[0]] <= pc_q;
            dep_q <= dep_q + 2'h1;
         end else if (ret_valid) begin
            dep_q <= dep_q - 2'h1;
         end
      end
   end
   property p_take_vec;
      irq_take |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073;
   endproperty
   a_take_vec: assert property (p_take_vec) else $error("bad vector");
   property p_take_cause; irq_take |-> $past(cpu_boundary) && !$past(cpu_reti); endproperty
   a_take_cause: assert property (p_take_cause) else $error("entry off boundary");
   property p_take_req; irq_take |-> $past(irq_pending); endproperty
   a_take_req: assert property (p_take_req) else $error("entry without request");
   property p_gate; !ge_q && !$past(ge_q) |-> !irq_pending; endproperty
   a_gate: assert property (p_gate) else $error("request with global off");
   property p_hold; $changed(irq_vector) || $changed(irq_level) |-> irq_take; endproperty
   a_hold: assert property (p_hold) else $error("vector moved");
   property p_ret_cause; ret_valid |-> $past(cpu_reti); endproperty
   a_ret_cause: assert property (p_ret_cause) else $error("stray return");
   property p_ret_pc; ret_valid |-> dep_q != 2'h0 && ret_pc == stk_q[~dep_q[0]]; endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("wrong return pc");
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
   c_high: cover property (irq_take && irq_level);
   c_ret: cover property (ret_valid);
   c_nest: cover property (ret_valid && dep_q == 2'h2);
endmodule

// ==== mcuic_cpu_model.sv ====
`timescale 1ns/1ns
module mcuic_cpu_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic hold_isr,
   input wire logic irq_take,
   input wire logic [15:0] irq_vector,
   input wire logic ret_valid,
   input wire logic [15:0] ret_pc,
   output logic cpu_boundary,
   output logic [15:0] cpu_pc,
   output logic cpu_reti
);
   logic [15:0] pc_q;
   logic [2:0] wait_q;
   logic [1:0] left_q;
   logic [1:0] depth_q;
   // An idle cycle after every instruction lets a jump land before the next one
   wire step_w = wait_q == 3'h0;
   // No return while an entry or a return is still landing, or one routine is popped twice
   wire ret_w = step_w && depth_q != 2'h0 && left_q == 2'h0 && !hold_isr && !irq_take &&
                !ret_valid;
   assign cpu_pc = pc_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pc_q <= 16'h0100;
         wait_q <= 3'h1;
         left_q <= 2'h0;
         depth_q <= 2'h0;
         cpu_boundary <= 1'b0;
         cpu_reti <= 1'b0;
      end else begin
         cpu_boundary <= step_w && !ret_w;
         cpu_reti <= ret_w;
         wait_q <= step_w ? (slow ? 3'h4 : 3'h1) : wait_q - 3'h1;
         if (irq_take) begin
            pc_q <= irq_vector;
            left_q <= 2'h3;
            depth_q <= depth_q + 2'h1;
         end else if (ret_valid) begin
            pc_q <= ret_pc;
            left_q <= 2'h3;
            depth_q <= depth_q - 2'h1;
         end else if (step_w) begin
            pc_q <= pc_q + 16'h0001;
            left_q <= left_q - {1'b0, left_q != 2'h0};
         end
      end
   end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] ext_pin = 5'h00;
   logic [7:0] kb_pin = 8'h00;
   logic [9:0] evt = 10'h000;
   logic slow = 1'b0;
   logic hold_isr = 1'b0;
   logic [7:0] reg_rdata;
   logic cpu_boundary, cpu_reti, irq_pending, irq_take, irq_level, ret_valid;
   logic [15:0] cpu_pc, irq_vector, ret_pc;
   int err_count = 0;
   int checks_done = 0;
   // Source per vector: below 16 an event line, 16+k pin k, 32 keyboard
   localparam int SRC [15] = '{16, 0, 17, 1, 2, 4, 5, 6, 32, 18, 7, 8, 19, 20, 9};
   always #20 core_clk = ~core_clk;
   mcuic_top mcuic_top_i (
      .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_pin,
      .kb_pin, .timer_zero_evt(evt[0]), .timer_one_evt(evt[1]), .uart_tx_evt(evt[2]),
      .uart_rx_evt(evt[3]), .timer_a_evt(evt[4]), .timer_b_evt(evt[5]),
      .timer_two_evt(evt[6]), .two_wire_evt(evt[7]), .low_voltage_evt(evt[8]),
      .watchdog_evt(evt[9]), .cpu_boundary, .cpu_pc, .cpu_reti, .irq_pending, .irq_take,
      .irq_vector, .irq_level, .ret_valid, .ret_pc
   );
   mcuic_cpu_model mcuic_cpu_model_i (
      .core_clk, .sys_rst, .slow, .hold_isr, .irq_take, .irq_vector, .ret_valid, .ret_pc,
      .cpu_boundary, .cpu_pc, .cpu_reti
   );
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata === exp, "read data");
   endtask
   task automatic fire(input int s);
      @(posedge core_clk);
      if (s == 32) kb_pin[0] <= ~kb_pin[0];
      else if (s >= 16) ext_pin[s - 16] <= 1'b1;
      else evt[s] <= 1'b1;
      @(posedge core_clk);
      evt <= 10'h000;
   endtask
   task automatic wait_ev(input logic want_take, input string msg);
      int n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while ((want_take ? irq_take : ret_valid) !== 1'b1 && n < 80);
      chk((want_take ? irq_take : ret_valid) === 1'b1, msg);
   endtask
   task automatic take(input logic [15:0] v, input logic l);
      wait_ev(1'b1, "no entry");
      chk(irq_vector === v && irq_level === l, "entry vector or level");
   endtask
   task automatic regs_test();
      logic [7:0] a [5] = '{8'h96, 8'ha8, 8'hb8, 8'hf8, 8'he8};
      foreach (a[i]) begin
         rd(a[i], 8'h00);
         wr(a[i], 8'hff);
         rd(a[i], 8'hff);
         wr(a[i], 8'h00);
      end
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
   endtask
   task automatic gate_test();
      fire(4);
      rd(8'hc0, 8'h40);
      chk(irq_pending === 1'b0, "request while disabled");
      wr(8'hc5, 8'h02);
      repeat (3) @(negedge core_clk);
      chk(irq_pending === 1'b0, "request with global off");
      wr(8'ha8, 8'h80);
      take(16'h002b, 1'b0);
      chk(irq_pending === 1'b1, "no request while flagged and enabled");
      wr(8'hc0, 8'hbf);
      wait_ev(1'b0, "no return");
      rd(8'hc0, 8'h00);
      wr(8'ha8, 8'h00);
   endtask
   task automatic pin_test();
      wr(8'hc3, 8'h00);
      wr(8'hc4, 8'h00);
      wr(8'hc2, 8'h1f);
      repeat (4) @(posedge core_clk);
      wr(8'hc0, 8'h00);
      rd(8'hc0, 8'h05);
      rd(8'hc1, 8'h64);
      wr(8'hc4, 8'h1f);
      repeat (3) @(posedge core_clk);
      wr(8'hc0, 8'h00);
      wr(8'hc1, 8'h00);
      rd(8'hc0, 8'h00);
      rd(8'hc1, 8'h00);
      wr(8'hc3, 8'h1f);
   endtask
   task automatic vector_test();
      wr(8'ha9, 8'h01);
      wr(8'hc5, 8'h07);
      // Keyboard lines sit idle and settled before their enable is set
      wr(8'he8, 8'haf);
      wr(8'ha8, 8'hbf);
      slow <= 1'b1;
      hold_isr <= 1'b1;
      for (int v = 0; v < 15; v++) begin
         fire(SRC[v]);
         take(16'h0003 + 16'(8 * v), 1'b0);
         wr(8'hc0, 8'h00);
         wr(8'hc1, 8'h00);
         hold_isr <= 1'b0;
         wait_ev(1'b0, "no return");
         hold_isr <= 1'b1;
      end
   endtask
   task automatic prio_test();
      slow <= 1'b0;
      @(posedge core_clk);
      evt[1] <= 1'b1;
      evt[9] <= 1'b1;
      @(posedge core_clk);
      evt <= 10'h000;
      take(16'h001b, 1'b0);
      rd(8'hc0, 8'h00);
      rd(8'hc1, 8'h80);
      wr(8'hf8, 8'h20);
      take(16'h0073, 1'b1);
      rd(8'hc6, 8'h0b);
      wr(8'hc1, 8'h00);
      wr(8'hb8, 8'h10);
      fire(3);
      repeat (20) begin
         @(negedge core_clk);
         chk(irq_take !== 1'b1, "same level entered");
      end
      hold_isr <= 1'b0;
      wait_ev(1'b0, "no return");
      take(16'h0023, 1'b1);
      wr(8'hc0, 8'h00);
      wait_ev(1'b0, "no return");
      wait_ev(1'b0, "no return");
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      regs_test();
      gate_test();
      pin_test();
      vector_test();
      prio_test();
      results();
   end
   initial begin
      #400000;
      err_count++;
      results();
   end
endmodule
bind mcuic_top mcuic_properties mcuic_properties_i (
   .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_boundary,
   .cpu_pc, .cpu_reti, .irq_pending, .irq_take, .irq_vector, .irq_level, .ret_valid, .ret_pc
);
